// File: slc_pkg.sv
// Shared constants and types for the speed loop compensation drive block
package slc_pkg;
   // -------------------------------------------------------------
   // Configuration register offsets
   // -------------------------------------------------------------
   localparam logic CFG_ZERO_ADDR = 1'h0;
   localparam logic CFG_ONE_ADDR = 1'h1;
   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int ZC_MSB = 7;
   localparam int ZC_LSB = 5;
   localparam int COAST_BIT = 4;
   localparam int SYNC_BIT = 3;
   localparam int GAIN_MSB = 2;
   localparam int GAIN_LSB = 0;
   localparam int PC_MSB = 7;
   localparam int PC_LSB = 2;
   localparam int FGSEL_MSB = 1;
   localparam int FGSEL_LSB = 0;
   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic [2:0] ZC_CODE_DEF = 3'h4;
   localparam logic COAST_DEF = 1'b1;
   localparam logic [2:0] GAIN_CODE_DEF = 3'h0;
   localparam logic [5:0] PC_DEF = 6'h1C;
   localparam logic [1:0] FGSEL_DEF = 2'h1;
   localparam logic [6:0] ZC_BASE = 7'h78;
   // -------------------------------------------------------------
   // Datapath widths and PWM period
   // -------------------------------------------------------------
   localparam int INT_W = 14;
   localparam int INT_OUT_W = 10;
   localparam int FILT_W = 17;
   localparam int DUTY_W = 8;
   localparam logic [INT_W-1:0] INT_MAX = 14'h3FFF;
   localparam logic [DUTY_W-1:0] PWM_LAST = 8'hFE;
   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int DEAD_TIME_NS = 500;
   localparam int DEAD_CYC = (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int DEAD_W = $clog2(DEAD_CYC + 1);

   typedef enum logic [0:0] {SLC_DRIVE, SLC_COAST} slc_coast_t;
endpackage

// File: slc_filt_if.sv
// Connection between the loop top and the pole/zero filter
`timescale 1ns/1ps
interface slc_filt_if;
   logic clr;
   logic sample;
   logic [9:0] x;
   logic [5:0] pole_coefficient;
   logic [6:0] zero_coefficient;
   logic [7:0] duty;
   modport ctrl (output clr, output sample, output x, output pole_coefficient,
      output zero_coefficient, input duty);
   modport filt (input clr, input sample, input x, input pole_coefficient,
      input zero_coefficient, output duty);
endinterface

// File: slc_filter.sv
// First-order pole/zero compensation filter with saturated duty output
`timescale 1ns/1ps
module slc_filter
   import slc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Filter port
   slc_filt_if.filt f
);
   import slc_pkg::*;

   logic signed [FILT_W-1:0] y_reg, y_next;
   logic [INT_OUT_W-1:0] xp_reg, xp_next;
   logic [DUTY_W-1:0] duty_reg, duty_next;
   logic signed [25:0] a_pole;
   logic signed [25:0] a_in;
   logic signed [25:0] a_zero;
   logic signed [25:0] sum;
   logic signed [18:0] y_raw;

   function automatic logic signed [FILT_W-1:0] sat_state(input logic signed [18:0] v);
      if (v > 19'sd65535)
         return 17'sh0_FFFF;
      else if (v < -19'sd65536)
         return 17'sh1_0000;
      else
         return v[FILT_W-1:0];
   endfunction

   function automatic logic [DUTY_W-1:0] sat_duty(input logic signed [FILT_W-1:0] v);
      logic signed [14:0] q;
      q = v[16:2];
      if (q[14])
         return 8'h00;
      else if (q > 15'sd255)
         return 8'hFF;
      else
         return q[7:0];
   endfunction

   // ------------------------------------------------------------
   // Difference equation
   // ------------------------------------------------------------
   // y[n] = pole/128*y[n-1] + 0.25*(128*x[n] - zero*x[n-1]), all scaled by 128
   always_comb
   begin
      a_pole = 26'(signed'({1'b0, f.pole_coefficient}) * y_reg);
      a_in = signed'(26'(4096 * f.x));
      a_zero = signed'(26'(32 * f.zero_coefficient * xp_reg));
      sum = a_pole + a_in - a_zero;
      y_raw = 19'(sum >>> 7);
      y_next = y_reg;
      xp_next = xp_reg;
      duty_next = duty_reg;
      if (f.clr)
      begin
         y_next = '0;
         xp_next = '0;
         duty_next = '0;
      end
      else if (f.sample)
      begin
         // Internal word kept at 17 bits, clipped rather than wrapped
         y_next = sat_state(y_raw);
         xp_next = f.x;
         // Dropping two bits maps the 17-bit state onto the 8-bit command
         duty_next = sat_duty(sat_state(y_raw));
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         y_reg <= '0;
         xp_reg <= '0;
         duty_reg <= '0;
      end
      else
      begin
         y_reg <= y_next;
         xp_reg <= xp_next;
         duty_reg <= duty_next;
      end
   end

   assign f.duty = duty_reg;
endmodule // slc_filter

// File: slc_top.sv
// Speed loop integrator, compensation filter, PWM and gate drive logic
// Functional notes
// - Register zero bit 4 enables coast, default high
// - Coast on overspeed: highs off, lows keep sequencing
// - Coast ends when speed drops below reference
// - Coast overrides synchronous rectification when overspeed
// - Sync on: modulated phase low inverts high
// - Dead time on every half-bridge transition
// - Sync low turns on only after dead time
// - Sync off: low held off during off time
// - Sync default set by device variant
// - Integrator clock divided per bits 2..0 table
// - Integrator divide defaults to one, code 000
// - 14-bit integrator, upper 10 bits to filter
// - Pole coefficient register one bits 7..2, default 28
// - Zero coefficient is 120 plus bits 7..5
// - Zero code defaults to 100, value 124
// - Filter implements the pole/zero difference equation
// - Words: 10 integrator, 17 filter, 8 PWM
// - Sample period set by external sampling tick
// - Duty n out of 255 oscillator intervals
// - PWM carried on the high-side gate
`timescale 1ns/1ps
module slc_top
   import slc_pkg::*;
#(
   parameter logic SYNC_DEFAULT = 1'b1,
   parameter int PHASES = 3
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Configuration register load and readback
   input wire logic cfg_we_i,
   input wire logic cfg_addr_i,
   input wire logic [7:0] cfg_wdata_i,
   output logic [7:0] cfg_rdata_o,
   // Timing strobes
   input wire logic osc_tick_i,
   input wire logic sample_tick_i,
   // Loop status
   input wire logic clear_i,
   input wire logic err_up_i,
   input wire logic err_down_i,
   input wire logic over_ref_i,
   input wire logic below_ref_i,
   // Commutation table
   input wire logic [PHASES-1:0] comm_pwm_i,
   input wire logic [PHASES-1:0] comm_low_on_i,
   // Gate drives and observation
   output logic [PHASES-1:0] high_side_gate_drive_o,
   output logic [PHASES-1:0] low_side_gate_drive_o,
   output logic [slc_pkg::DUTY_W-1:0] duty_o,
   output logic [slc_pkg::INT_OUT_W-1:0] integ_word_o,
   output logic coast_o
);
   import slc_pkg::*;

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   localparam logic [7:0] CFG0_RST = {ZC_CODE_DEF, COAST_DEF, SYNC_DEFAULT, GAIN_CODE_DEF};
   localparam logic [7:0] CFG1_RST = {PC_DEF, FGSEL_DEF};

   logic [7:0] cfg0_reg, cfg0_next;
   logic [7:0] cfg1_reg, cfg1_next;
   logic [7:0] rdata_reg, rdata_next;
   logic coast_en;
   logic sync_en;
   logic [2:0] gain_code;

   always_comb
   begin
      cfg0_next = cfg0_reg;
      cfg1_next = cfg1_reg;
      if (cfg_we_i && cfg_addr_i == CFG_ZERO_ADDR)
         cfg0_next = cfg_wdata_i;
      if (cfg_we_i && cfg_addr_i == CFG_ONE_ADDR)
         cfg1_next = cfg_wdata_i;
      rdata_next = (cfg_addr_i == CFG_ONE_ADDR) ? cfg1_reg : cfg0_reg;
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         cfg0_reg <= CFG0_RST;
         cfg1_reg <= CFG1_RST;
         rdata_reg <= '0;
      end
      else
      begin
         cfg0_reg <= cfg0_next;
         cfg1_reg <= cfg1_next;
         rdata_reg <= rdata_next;
      end
   end

   assign cfg_rdata_o = rdata_reg;
   assign coast_en = cfg0_reg[COAST_BIT];
   assign sync_en = cfg0_reg[SYNC_BIT];
   assign gain_code = cfg0_reg[GAIN_MSB:GAIN_LSB];

   // ------------------------------------------------------------
   // Integrator clock divider and 14-bit integrator
   // ------------------------------------------------------------
   // Codes are not monotonic in the divide ratio, hence the table
   function automatic logic [3:0] div_last(input logic [2:0] code);
      unique case (code)
         3'h0: return 4'h0;
         3'h2: return 4'h1;
         3'h1: return 4'h2;
         3'h4: return 4'h3;
         3'h3: return 4'h5;
         3'h6: return 4'h7;
         3'h5: return 4'hB;
         3'h7: return 4'hF;
      endcase
   endfunction

   logic [3:0] div_reg, div_next;
   logic [INT_W-1:0] int_reg, int_next;
   logic int_tick;

   always_comb
   begin
      int_tick = 1'b0;
      div_next = div_reg;
      int_next = int_reg;
      if (clear_i)
      begin
         div_next = '0;
         int_next = '0;
      end
      else
      begin
         if (osc_tick_i)
         begin
            if (div_reg >= div_last(gain_code))
            begin
               div_next = '0;
               int_tick = 1'b1;
            end
            else
               div_next = div_reg + 4'h1;
         end
         // Saturate at both ends so a long error burst cannot wrap the drive
         if (int_tick && err_up_i && !err_down_i && int_reg != INT_MAX)
            int_next = int_reg + 14'h0001;
         else if (int_tick && err_down_i && !err_up_i && int_reg != '0)
            int_next = int_reg - 14'h0001;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         div_reg <= '0;
         int_reg <= '0;
      end
      else
      begin
         div_reg <= div_next;
         int_reg <= int_next;
      end
   end

   assign integ_word_o = int_reg[INT_W-1:INT_W-INT_OUT_W];

   // ------------------------------------------------------------
   // Compensation filter
   // ------------------------------------------------------------
   slc_filt_if fbus ();

   assign fbus.clr = clear_i;
   // Filter runs only on the sampling strobe, so its pole and zero follow Ts
   assign fbus.sample = sample_tick_i;
   assign fbus.x = int_reg[INT_W-1:INT_W-INT_OUT_W];
   assign fbus.pole_coefficient = cfg1_reg[PC_MSB:PC_LSB];
   assign fbus.zero_coefficient = ZC_BASE + {4'h0, cfg0_reg[ZC_MSB:ZC_LSB]};

   slc_filter u_filter (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .f(fbus)
   );

   // ------------------------------------------------------------
   // PWM generator
   // ------------------------------------------------------------
   logic [DUTY_W-1:0] pcnt_reg, pcnt_next;
   logic [DUTY_W-1:0] duty_reg, duty_next;
   logic pwm_on;

   always_comb
   begin
      pcnt_next = pcnt_reg;
      duty_next = duty_reg;
      if (osc_tick_i)
      begin
         if (pcnt_reg >= PWM_LAST)
         begin
            pcnt_next = '0;
            // New command only at period start, so no runt pulses
            duty_next = fbus.duty;
         end
         else
            pcnt_next = pcnt_reg + 8'h01;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pcnt_reg <= '0;
         duty_reg <= '0;
      end
      else
      begin
         pcnt_reg <= pcnt_next;
         duty_reg <= duty_next;
      end
   end

   assign pwm_on = pcnt_reg < duty_reg;
   assign duty_o = duty_reg;

   // ------------------------------------------------------------
   // Coast control
   // ------------------------------------------------------------
   slc_coast_t coast_reg, coast_next;

   always_comb
   begin
      coast_next = coast_reg;
      unique case (coast_reg)
         SLC_DRIVE:
            if (coast_en && over_ref_i && !clear_i)
               coast_next = SLC_COAST;
         SLC_COAST:
            if (below_ref_i || !coast_en || clear_i)
               coast_next = SLC_DRIVE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         coast_reg <= SLC_DRIVE;
      else
         coast_reg <= coast_next;
   end

   assign coast_o = coast_reg == SLC_COAST;

   // ------------------------------------------------------------
   // Gate drive with dead time
   // ------------------------------------------------------------
   logic [PHASES-1:0] hs_reg, hs_next;
   logic [PHASES-1:0] ls_reg, ls_next;
   logic [PHASES-1:0] hs_want;
   logic [PHASES-1:0] ls_want;
   logic [DEAD_W-1:0] dead_reg [PHASES], dead_next [PHASES];

   always_comb
   begin
      for (int p = 0; p < PHASES; p++)
      begin
         // High side carries the switching; coast blanks it
         hs_want[p] = comm_pwm_i[p] && pwm_on && !coast_o && !clear_i;
         // Coast also suppresses the rectifying low pulse
         ls_want[p] = !clear_i && (comm_low_on_i[p] || (comm_pwm_i[p] && !pwm_on && sync_en
                      && !coast_o));
         hs_next[p] = hs_reg[p];
         ls_next[p] = ls_reg[p];
         dead_next[p] = dead_reg[p];
         if (hs_want[p] == hs_reg[p] && ls_want[p] == ls_reg[p])
            dead_next[p] = dead_reg[p];
         else if (hs_reg[p] || ls_reg[p])
         begin
            // Any change passes through both-off before the other side may rise
            hs_next[p] = hs_reg[p] && hs_want[p];
            ls_next[p] = ls_reg[p] && ls_want[p];
            dead_next[p] = DEAD_W'(DEAD_CYC);
         end
         else if (dead_reg[p] != '0)
            dead_next[p] = dead_reg[p] - 1'b1;
         else
         begin
            hs_next[p] = hs_want[p];
            ls_next[p] = ls_want[p] && !hs_want[p];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         hs_reg <= '0;
         ls_reg <= '0;
         for (int p = 0; p < PHASES; p++)
            dead_reg[p] <= '0;
      end
      else
      begin
         hs_reg <= hs_next;
         ls_reg <= ls_next;
         for (int p = 0; p < PHASES; p++)
            dead_reg[p] <= dead_next[p];
      end
   end

   assign high_side_gate_drive_o = hs_reg;
   assign low_side_gate_drive_o = ls_reg;
endmodule // slc_top

// File: slc_monitor.sv
// Port-level assertions for the speed loop compensation drive
`timescale 1ns/1ps
module slc_monitor
   import slc_pkg::*;
#(
   parameter int PHASES = 3
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Inputs
   input wire logic osc_tick_i,
   input wire logic clear_i,
   input wire logic err_up_i,
   input wire logic err_down_i,
   input wire logic over_ref_i,
   input wire logic below_ref_i,
   input wire logic [PHASES-1:0] comm_pwm_i,
   // Outputs
   input wire logic [PHASES-1:0] high_side_gate_drive_o,
   input wire logic [PHASES-1:0] low_side_gate_drive_o,
   input wire logic [slc_pkg::DUTY_W-1:0] duty_o,
   input wire logic [slc_pkg::INT_OUT_W-1:0] integ_word_o,
   input wire logic coast_o
);
   import slc_pkg::*;

   // ----------------------------------------
   // Idle time of phase 0, starts saturated so the first turn-on passes
   // ----------------------------------------
   logic [5:0] off_reg;
   logic [5:0] off_next;
   wire [PHASES-1:0] hs = high_side_gate_drive_o;
   wire [PHASES-1:0] ls = low_side_gate_drive_o;
   always_comb
   begin
      off_next = off_reg;
      if (hs[0] | ls[0])
         off_next = 6'h00;
      else if (off_reg != 6'h3F)
         off_next = off_reg + 6'h01;
   end
   always_ff @(posedge clk_i or negedge rst_b_i)
      if (!rst_b_i)
         off_reg <= 6'h3F;
      else
         off_reg <= off_next;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_coasting;
      coast_o ##1 coast_o;
   endsequence
   sequence s_clear_held;
      clear_i [*3];
   endsequence
   a_gates_exclusive: assert property ((hs & ls) == '0)
      else $error("high and low gate on together");
   a_low_dead_gap: assert property ($rose(ls[0]) |-> off_reg >= DEAD_CYC)
      else $error("low gate on before dead time");
   a_high_dead_gap: assert property ($rose(hs[0]) |-> off_reg >= DEAD_CYC)
      else $error("high gate on before dead time");
   a_coast_highs_off: assert property (s_coasting |-> hs == '0)
      else $error("high gate on while coasting");
   a_coast_cause: assert property ($rose(coast_o) |-> $past(over_ref_i))
      else $error("coast entered without overspeed");
   a_coast_release: assert property (coast_o && below_ref_i |-> ##[1:2] !coast_o)
      else $error("coast held below reference");
   a_clear_state: assert property (s_clear_held |->
      (hs | ls) == '0 && !coast_o && integ_word_o == '0)
      else $error("clear state not honoured");
   a_integ_step: assert property (integ_word_o != $past(integ_word_o) |->
      integ_word_o - $past(integ_word_o) inside {10'h001, 10'h3FF} || $past(clear_i))
      else $error("integrator word jumped");
   a_integ_dir: assert property (integ_word_o > $past(integ_word_o) |->
      $past(err_up_i) && !$past(err_down_i))
      else $error("integrator rose without up error");
   a_duty_on_tick: assert property ($changed(duty_o) |-> $past(osc_tick_i) || $past(clear_i))
      else $error("duty changed off an oscillator tick");
   a_pwm_on_high: assert property ($rose(hs[0]) |-> $past(comm_pwm_i[0]))
      else $error("high gate on without pwm phase");
endmodule // slc_monitor

bind slc_top slc_monitor #(.PHASES(PHASES)) i_mon (.clk_i(clk_i), .rst_b_i(rst_b_i),
   .osc_tick_i(osc_tick_i), .clear_i(clear_i), .err_up_i(err_up_i), .err_down_i(err_down_i),
   .over_ref_i(over_ref_i), .below_ref_i(below_ref_i), .comm_pwm_i(comm_pwm_i),
   .high_side_gate_drive_o(high_side_gate_drive_o), .low_side_gate_drive_o(low_side_gate_drive_o),
   .duty_o(duty_o), .integ_word_o(integ_word_o), .coast_o(coast_o));

// File: slc_bridge_model.sv
// Half-bridge power stage stand-in that watches the gate drives
`timescale 1ns/1ps
module slc_bridge_model
#(
   parameter int PHASES = 3
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Gate drives
   input wire logic [PHASES-1:0] high_side_gate_drive_i,
   input wire logic [PHASES-1:0] low_side_gate_drive_i,
   // Stage status
   output logic shoot_o,
   output logic [15:0] lo_rise_o
);
   logic lo_last_reg;
   // Sticky, since one overlap would destroy a real bridge
   always_ff @(posedge clk_i or negedge rst_b_i)
      if (!rst_b_i)
      begin
         shoot_o <= 1'b0;
         lo_rise_o <= 16'h0000;
         lo_last_reg <= 1'b0;
      end
      else
      begin
         if ((high_side_gate_drive_i & low_side_gate_drive_i) != '0)
            shoot_o <= 1'b1;
         if (low_side_gate_drive_i[0] & !lo_last_reg)
            lo_rise_o <= lo_rise_o + 16'h0001;
         lo_last_reg <= low_side_gate_drive_i[0];
      end
endmodule // slc_bridge_model

// File: speed_loop_compensation_drive_bench.sv
// Self-checking bench for the speed loop compensation drive
`timescale 1ns/1ps
module speed_loop_compensation_drive_bench;
   import slc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic cfg_we_i = 1'b0;
   logic cfg_addr_i = 1'b0;
   logic [7:0] cfg_wdata_i = 8'h00;
   logic osc_tick_i = 1'b0;
   logic sample_tick_i = 1'b0;
   logic clear_i = 1'b0;
   logic err_up_i = 1'b0;
   logic err_down_i = 1'b0;
   logic over_ref_i = 1'b0;
   logic below_ref_i = 1'b0;
   logic [2:0] comm_pwm_i = 3'h0;
   logic [2:0] comm_low_on_i = 3'h0;
   logic [7:0] rdata;
   logic [2:0] hs;
   logic [2:0] ls;
   logic [7:0] duty;
   logic [9:0] integ;
   logic coast;
   logic shoot;
   logic [15:0] lo_rise;
   logic [15:0] r0;
   logic [7:0] cfg_m [2];
   int err_count = 0;
   int n_tests = 0;
   int dv [8] = '{1, 3, 2, 6, 4, 12, 8, 16};
   integer seed = 32'hfc33_2255;
   integer y;
   integer xp;
   integer e;
   integer pole;
   integer c;
   integer q [$];
   always #12.5 clk_i = ~clk_i;
   slc_top i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_we_i(cfg_we_i),
      .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(rdata),
      .osc_tick_i(osc_tick_i), .sample_tick_i(sample_tick_i), .clear_i(clear_i),
      .err_up_i(err_up_i), .err_down_i(err_down_i), .over_ref_i(over_ref_i),
      .below_ref_i(below_ref_i), .comm_pwm_i(comm_pwm_i), .comm_low_on_i(comm_low_on_i),
      .high_side_gate_drive_o(hs), .low_side_gate_drive_o(ls), .duty_o(duty),
      .integ_word_o(integ), .coast_o(coast));
   slc_bridge_model i_fet (.clk_i(clk_i), .rst_b_i(rst_b_i), .high_side_gate_drive_i(hs),
      .low_side_gate_drive_i(ls), .shoot_o(shoot), .lo_rise_o(lo_rise));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_word({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic stop_test;
      $display("tests %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic wr(input logic a, input logic [7:0] d);
      @(negedge clk_i);
      cfg_we_i = 1'b1;
      cfg_addr_i = a;
      cfg_wdata_i = d;
      cfg_m[a] = d;
      @(negedge clk_i);
      cfg_we_i = 1'b0;
   endtask
   task automatic rd(input logic a);
      @(negedge clk_i);
      cfg_addr_i = a;
      cyc(2);
      cmp_word({8'h00, rdata}, {8'h00, cfg_m[a]});
   endtask
   // Tick spacing is randomised; the loop only counts ticks
   task automatic tick(input int n);
      repeat (n)
      begin
         @(negedge clk_i);
         osc_tick_i = 1'b1;
         @(negedge clk_i);
         osc_tick_i = 1'b0;
         repeat ($random(seed) & 1) @(negedge clk_i);
      end
   endtask
   task automatic clr;
      @(negedge clk_i);
      clear_i = 1'b1;
      cyc(4);
      clear_i = 1'b0;
   endtask
   task automatic do_reset;
      rst_b_i = 1'b0;
      cyc(10);
      rst_b_i = 1'b1;
      cfg_m[0] = 8'h98;
      cfg_m[1] = 8'h71;
      rd(1'b0);
      rd(1'b1);
   endtask
   initial
   begin
      #(25 * 100000);
      err_count++;
      stop_test;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      do_reset;
      for (int i = 0; i < 8; i++)
      begin
         wr(1'b0, {5'b10011, i[2:0]});
         clr;
         err_up_i = 1'b1;
         tick(dv[i] * 48);
         cyc(4);
         err_up_i = 1'b0;
         cmp_word(16'(integ), 16'h0003);
      end
      err_down_i = 1'b1;
      tick(256);
      cyc(4);
      err_down_i = 1'b0;
      cmp_word(16'(integ), 16'h0002);
      wr(1'b0, 8'h98);
      clr;
      err_up_i = 1'b1;
      tick(1600);
      cyc(4);
      err_up_i = 1'b0;
      cmp_word(16'(integ), 16'h0064);
      y = 0;
      xp = 0;
      for (int i = 0; i < 11; i++)
      begin
         c = (i < 8) ? i : 4;
         pole = (i < 8) ? ($random(seed) & 63) : 28;
         wr(1'b1, {pole[5:0], 2'b01});
         wr(1'b0, {c[2:0], 5'b11000});
         rd(1'b1);
         @(negedge clk_i);
         sample_tick_i = 1'b1;
         @(negedge clk_i);
         sample_tick_i = 1'b0;
         y = (pole * y + 4096 * 100 - 32 * (120 + c) * xp) >>> 7;
         y = (y > 65535) ? 65535 : ((y < -65536) ? -65536 : y);
         xp = 100;
         e = y >>> 2;
         e = (e > 255) ? 255 : ((e < 0) ? 0 : e);
         q.push_back(e);
         tick(520);
         cmp_word(16'(duty), 16'(q.pop_front()));
      end
      comm_pwm_i = 3'h1;
      comm_low_on_i = 3'h2;
      tick(100);
      r0 = lo_rise;
      tick(520);
      cmp_bit(lo_rise != r0, 1'b1);
      over_ref_i = 1'b1;
      tick(10);
      cmp_bit(coast, 1'b1);
      r0 = lo_rise;
      tick(520);
      cmp_word({10'h000, hs, ls}, 16'h0002);
      cmp_word(lo_rise - r0, 16'h0000);
      over_ref_i = 1'b0;
      below_ref_i = 1'b1;
      tick(10);
      cmp_bit(coast, 1'b0);
      below_ref_i = 1'b0;
      wr(1'b0, 8'h88);
      over_ref_i = 1'b1;
      tick(10);
      cmp_bit(coast, 1'b0);
      over_ref_i = 1'b0;
      wr(1'b0, 8'h90);
      tick(100);
      r0 = lo_rise;
      tick(520);
      cmp_word(lo_rise - r0, 16'h0000);
      cmp_bit(shoot, 1'b0);
      do_reset;
      stop_test;
   end
endmodule // speed_loop_compensation_drive_bench
